// file: hw/port_ts_pkg.sv
// How it works
// - A port T polarity bit picks a pull-up when 0 and a pull-down when 1, only for an enabled input pin.
// - Each of the five port T routing bits ties its pin to the timer when 0 and to the modulator when 1.
// - A port S data read gives the stored value for output pins and the sampled pin level for the others.
// - Port S pin 1 is forced to output while the serial transmitter is on, pin 0 to input while its receiver is on.
// - The port S pin-level register always returns the real levels on all four pins.
// - Writes to the port S pin-level register are ignored and change nothing.
// - A port S direction bit makes its pin an input when 0 and an output when 1.
// - While a serial channel is on its direction bit has no effect, and control returns to the bit when it is off.
// - After a direction change the data and pin-level reads may lag up to three cycles: one in the pin output flops, two in the synchronisers.
// - A port S reduced-drive bit picks full strength when 0 and one third when 1, and is ignored on inputs.
// - A port S pull-enable bit acts on inputs and open-drain outputs, never on push-pull outputs.
// - After reset the port S pulls are enabled with pull-up polarity.
// - A port S polarity bit picks a pull-up when 0 (inputs and open-drain) and a pull-down when 1 (inputs only).
// - A port T pull-enable bit acts only on an input pin, and all port T pulls are off after reset.
// - A port S pin in open-drain mode drives low only and leaves the pin undriven for a one.
package port_ts_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PORT_T_W = 8;
  localparam int ROUTE_W  = 5;
  localparam int PORT_S_W = 4;
  localparam int ADDR_W   = 12;

  typedef logic [3:0] regIdx_t;

  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  localparam regIdx_t IDX_T_PULL_EN   = 4'h4;
  localparam regIdx_t IDX_T_PULL_POL  = 4'h5;
  localparam regIdx_t IDX_T_ROUTING   = 4'h7;
  localparam regIdx_t IDX_S_DATA      = 4'h8;
  localparam regIdx_t IDX_S_LEVELS    = 4'h9;
  localparam regIdx_t IDX_S_DIR       = 4'ha;
  localparam regIdx_t IDX_S_DRIVE     = 4'hb;
  localparam regIdx_t IDX_S_PULL_EN   = 4'hc;
  localparam regIdx_t IDX_S_PULL_POL  = 4'hd;
  localparam regIdx_t IDX_S_OPEN_DRN  = 4'he;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SERIAL_TX_PIN = 1;
  localparam int SERIAL_RX_PIN = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_T_PULL_EN  = 8'h00;
  localparam logic [7:0] RST_T_PULL_POL = 8'h00;
  localparam logic [4:0] RST_T_ROUTING  = 5'h00;
  localparam logic [3:0] RST_S_DATA     = 4'h0;
  localparam logic [3:0] RST_S_DIR      = 4'h0;
  localparam logic [3:0] RST_S_DRIVE    = 4'h0;
  localparam logic [3:0] RST_S_PULL_EN  = 4'hf;
  localparam logic [3:0] RST_S_PULL_POL = 4'h0;
  localparam logic [3:0] RST_S_OPEN_DRN = 4'h0;

endpackage

// file: hw/pin_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for pin levels; first stage feeds only the second
module pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             clkEn,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output      logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------
  // Two flops, frozen by the clock enable
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else if (clkEn) begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// file: hw/port_ts_ctrl.sv
`timescale 1ns/1ns
module port_ts_ctrl
  import port_ts_pkg::*;
#(
  parameter int TW = port_ts_pkg::PORT_T_W,
  parameter int RW = port_ts_pkg::ROUTE_W,
  parameter int SW = port_ts_pkg::PORT_S_W
) (
  // Clock, reset, enable
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  input  wire logic                          clkEn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [port_ts_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output      logic [31:0]                   prdata,
  output      logic                          pready,
  output      logic                          pslverr,
  // Port T context from the rest of the chip
  input  wire logic [TW-1:0]                 portTDirIn,
  input  wire logic [RW-1:0]                 timerOut,
  input  wire logic [RW-1:0]                 pwmOut,
  // Port T controls
  output      logic [RW-1:0]                 portTToModulator,
  output      logic [RW-1:0]                 portTPeriphOut,
  output      logic [TW-1:0]                 portTPullUp,
  output      logic [TW-1:0]                 portTPullDown,
  // Serial unit
  input  wire logic                          serialTxEn,
  input  wire logic                          serialRxEn,
  input  wire logic                          serialTxData,
  output      logic                          serialRxData,
  // Port S pins
  input  wire logic [SW-1:0]                 portSPinIn,
  output      logic [SW-1:0]                 portSPinOut,
  output      logic [SW-1:0]                 portSPinOeN,
  output      logic [SW-1:0]                 portSReducedDrive,
  output      logic [SW-1:0]                 portSPullUp,
  output      logic [SW-1:0]                 portSPullDown
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [TW-1:0] tPullEn_q;
  logic [TW-1:0] tPullPol_q;
  logic [RW-1:0] tRoute_q;
  logic [SW-1:0] sData_q;
  logic [SW-1:0] sDir_q;
  logic [SW-1:0] sDrive_q;
  logic [SW-1:0] sPullEn_q;
  logic [SW-1:0] sPullPol_q;
  logic [SW-1:0] sOpenDrn_q;
  logic [31:0]   rdata_d;
  logic          pready_d;
  logic          pslverr_d;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [SW-1:0] sLevel;

  // Levels reach software two cycles late after any pin change
  pin_sync #(
    .WIDTH (SW)
  ) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .clkEn   (clkEn),
    .asyncIn (portSPinIn),
    .syncOut (sLevel)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire           access   = psel & penable;
  wire           wordAlgn = (paddr[1:0] == 2'b00);
  wire           upperZero = (paddr[port_ts_pkg::ADDR_W-1:6] == '0);
  wire regIdx_t  idx      = paddr[5:2];
  wire           lane0    = pstrb[0];
  wire           hitTPe   = (idx == IDX_T_PULL_EN);
  wire           hitTPol  = (idx == IDX_T_PULL_POL);
  wire           hitRoute = (idx == IDX_T_ROUTING);
  wire           hitSData = (idx == IDX_S_DATA);
  wire           hitSLvl  = (idx == IDX_S_LEVELS);
  wire           hitSDir  = (idx == IDX_S_DIR);
  wire           hitSDrv  = (idx == IDX_S_DRIVE);
  wire           hitSPe   = (idx == IDX_S_PULL_EN);
  wire           hitSPol  = (idx == IDX_S_PULL_POL);
  wire           hitSOd   = (idx == IDX_S_OPEN_DRN);
  wire           anyHit   = hitTPe | hitTPol | hitRoute | hitSData | hitSLvl |
                            hitSDir | hitSDrv | hitSPe | hitSPol | hitSOd;
  wire           mapped   = wordAlgn & upperZero & anyHit;
  // A write lands only at the edge that completes the access
  wire           wrEn     = access & pready & pwrite & lane0 & mapped;

  // ----------------------------------------
  // Effective port S direction
  // ----------------------------------------
  // Serial channels override the direction bits without touching them
  logic [SW-1:0] sDirEff;
  always_comb begin
    sDirEff = sDir_q;
    if (serialTxEn) begin
      sDirEff[SERIAL_TX_PIN] = 1'b1;
    end
    if (serialRxEn) begin
      sDirEff[SERIAL_RX_PIN] = 1'b0;
    end
  end

  // Output value: serial transmit data replaces the data bit
  logic [SW-1:0] sOutVal;
  always_comb begin
    sOutVal = sData_q;
    if (serialTxEn) begin
      sOutVal[SERIAL_TX_PIN] = serialTxData;
    end
  end

  // ----------------------------------------
  // Port S pin drive terms
  // ----------------------------------------
  // Open-drain drives only a low; a one releases the pin
  wire [SW-1:0] sDriving   = sDirEff & ~(sOpenDrn_q & sOutVal);
  wire [SW-1:0] sOeN_d     = ~sDriving;
  wire [SW-1:0] sOut_d     = sOutVal & ~sOpenDrn_q;
  // Strength only matters while the pin is an output
  wire [SW-1:0] sRedDrv_d  = sDrive_q & sDirEff;
  // Pulls work on inputs and open-drain outputs, never push-pull
  wire [SW-1:0] sPullOk    = sPullEn_q & (~sDirEff | sOpenDrn_q);
  wire [SW-1:0] sPullUp_d  = sPullOk & ~sPullPol_q;
  // A pull-down is offered on inputs only
  wire [SW-1:0] sPullDn_d  = sPullOk & sPullPol_q & ~sDirEff;

  // ----------------------------------------
  // Port T pin terms
  // ----------------------------------------
  wire [TW-1:0] tPullOk    = tPullEn_q & ~portTDirIn;
  wire [TW-1:0] tPullUp_d  = tPullOk & ~tPullPol_q;
  wire [TW-1:0] tPullDn_d  = tPullOk & tPullPol_q;
  // Routing bit picks the source that reaches the pin
  wire [RW-1:0] tPeriph_d  = (tRoute_q & pwmOut) | (~tRoute_q & timerOut);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Output pins read the latch, others the synchronised level
  wire [SW-1:0] sDataRd    = (sDirEff & sData_q) | (~sDirEff & sLevel);
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (1'b1)
      hitTPe:   rdata_d[TW-1:0] = tPullEn_q;
      hitTPol:  rdata_d[TW-1:0] = tPullPol_q;
      hitRoute: rdata_d[RW-1:0] = tRoute_q;
      hitSData: rdata_d[SW-1:0] = sDataRd;
      hitSLvl:  rdata_d[SW-1:0] = sLevel;
      hitSDir:  rdata_d[SW-1:0] = sDir_q;
      hitSDrv:  rdata_d[SW-1:0] = sDrive_q;
      hitSPe:   rdata_d[SW-1:0] = sPullEn_q;
      hitSPol:  rdata_d[SW-1:0] = sPullPol_q;
      hitSOd:   rdata_d[SW-1:0] = sOpenDrn_q;
      default:  rdata_d = 32'h0000_0000;
    endcase
    if (!mapped) begin
      rdata_d = 32'h0000_0000;
    end
  end

  // One wait state: ready rises in the second access cycle
  assign pready_d  = access & ~pready;
  assign pslverr_d = access & ~pready & ~mapped;

  // ----------------------------------------
  // Bus answer flops
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clkEn) begin
      pready  <= pready_d;
      pslverr <= pslverr_d;
      prdata  <= (access & ~pready & ~pwrite) ? rdata_d : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Port T registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tPullEn_q  <= RST_T_PULL_EN;
      tPullPol_q <= RST_T_PULL_POL;
      tRoute_q   <= RST_T_ROUTING;
    end else if (clkEn && wrEn) begin
      if (hitTPe)   tPullEn_q  <= pwdata[TW-1:0];
      if (hitTPol)  tPullPol_q <= pwdata[TW-1:0];
      if (hitRoute) tRoute_q   <= pwdata[RW-1:0];
    end
  end

  // ----------------------------------------
  // Port S registers
  // ----------------------------------------
  // The pin-level index has no write branch, so writes fall away
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sData_q    <= RST_S_DATA;
      sDir_q     <= RST_S_DIR;
      sDrive_q   <= RST_S_DRIVE;
      sPullEn_q  <= RST_S_PULL_EN;
      sPullPol_q <= RST_S_PULL_POL;
      sOpenDrn_q <= RST_S_OPEN_DRN;
    end else if (clkEn && wrEn) begin
      if (hitSData) sData_q    <= pwdata[SW-1:0];
      if (hitSDir)  sDir_q     <= pwdata[SW-1:0];
      if (hitSDrv)  sDrive_q   <= pwdata[SW-1:0];
      if (hitSPe)   sPullEn_q  <= pwdata[SW-1:0];
      if (hitSPol)  sPullPol_q <= pwdata[SW-1:0];
      if (hitSOd)   sOpenDrn_q <= pwdata[SW-1:0];
    end
  end

  // ----------------------------------------
  // Registered pin and peripheral outputs
  // ----------------------------------------
  // One cycle of lag keeps every output glitch-free off a flop
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      portSPinOut       <= '0;
      portSPinOeN       <= '1;
      portSReducedDrive <= '0;
      portSPullUp       <= '0;
      portSPullDown     <= '0;
      portTPullUp       <= '0;
      portTPullDown     <= '0;
      portTToModulator  <= '0;
      portTPeriphOut    <= '0;
      serialRxData      <= 1'b1;
    end else if (clkEn) begin
      portSPinOut       <= sOut_d;
      portSPinOeN       <= sOeN_d;
      portSReducedDrive <= sRedDrv_d;
      portSPullUp       <= sPullUp_d;
      portSPullDown     <= sPullDn_d;
      portTPullUp       <= tPullUp_d;
      portTPullDown     <= tPullDn_d;
      portTToModulator  <= tRoute_q;
      portTPeriphOut    <= tPeriph_d;
      serialRxData      <= sLevel[SERIAL_RX_PIN];
    end
  end

endmodule

// file: bench/port_ts_checker.sv
`timescale 1ns/1ns
module port_ts_checker #(
  parameter int TW = 8,
  parameter int RW = 5,
  parameter int SW = 4
) (
  // Clock and reset
  input wire logic          sys_clk,
  input wire logic          nrst,
  input wire logic          clkEn,
  // Bus
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [31:0]   prdata,
  // Port T
  input wire logic [TW-1:0] portTDirIn,
  input wire logic [RW-1:0] timerOut,
  input wire logic [RW-1:0] pwmOut,
  input wire logic [RW-1:0] portTToModulator,
  input wire logic [RW-1:0] portTPeriphOut,
  input wire logic [TW-1:0] portTPullUp,
  input wire logic [TW-1:0] portTPullDown,
  // Port S and serial
  input wire logic          serialTxEn,
  input wire logic          serialRxEn,
  input wire logic          serialTxData,
  input wire logic [SW-1:0] portSPinOut,
  input wire logic [SW-1:0] portSPinOeN,
  input wire logic [SW-1:0] portSPullDown
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Bus answer: one wait state, one-cycle pulse, error only with it
  chk_one_wait: assert property (psel && penable && !pready && clkEn |=> pready)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  // Pin controls; $past(nrst) skips the edge right after reset
  chk_route_mux: assert property ($past(nrst) && $past(clkEn) |->
    portTPeriphOut == ((portTToModulator & $past(pwmOut)) | (~portTToModulator & $past(timerOut))))
    else $error("port T routing wrong");
  chk_t_pull: assert property ($past(nrst) && $past(clkEn) |->
    ((portTPullUp & portTPullDown) | ((portTPullUp | portTPullDown) & $past(portTDirIn))) == '0)
    else $error("port T pull on output or both pulls");
  chk_s_pulldown: assert property ((portSPullDown & ~portSPinOeN) == '0)
    else $error("port S pull-down on driven pin");
  chk_tx_pin: assert property ($past(nrst) && $past(clkEn) && $past(serialTxEn) |->
    !portSPinOeN[1] && portSPinOut[1] == $past(serialTxData))
    else $error("transmit pin not driven");
  chk_rx_pin: assert property ($past(nrst) && $past(clkEn) && $past(serialRxEn) |-> portSPinOeN[0])
    else $error("receive pin driven");
endmodule

bind port_ts_ctrl port_ts_checker #(.TW(TW), .RW(RW), .SW(SW)) u_chk (.sys_clk, .nrst, .clkEn, .psel,
  .penable, .pready, .pslverr, .prdata, .portTDirIn, .timerOut, .pwmOut, .portTToModulator,
  .portTPeriphOut, .portTPullUp, .portTPullDown, .serialTxEn, .serialRxEn, .serialTxData,
  .portSPinOut, .portSPinOeN, .portSPullDown);

// file: bench/pin_model.sv
`timescale 1ns/1ns
module pin_model (
  // Clock
  input  wire logic       sys_clk,
  // Pad controls from the block
  input  wire logic [3:0] pinOut,
  input  wire logic [3:0] pinOeN,
  input  wire logic [3:0] pullUp,
  input  wire logic [3:0] pullDown,
  // Outside source, stiff enough to short a driver
  input  wire logic [3:0] extEn,
  input  wire logic [3:0] extVal,
  // Pad level
  output      logic [3:0] level
);
  logic [3:0] last_q = 4'h0;

  // Source, then driver, then pulls; a floating pad toggles so no value is settled by chance
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (extEn[i])
        level[i] = extVal[i];
      else if (!pinOeN[i])
        level[i] = pinOut[i];
      else if (pullUp[i])
        level[i] = 1'b1;
      else if (pullDown[i])
        level[i] = 1'b0;
      else
        level[i] = ~last_q[i];
    end
  end

  // Last level, for the floating pattern
  always_ff @(posedge sys_clk) last_q <= level;
endmodule

// file: bench/tb_port_ts_ctrl.sv
`timescale 1ns/1ns
module tb_port_ts_ctrl;
  import port_ts_pkg::*;
  // --------
  // Signals
  // --------
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clkEn = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [7:0]  portTDirIn = 8'h00;
  logic [4:0]  timerOut = 5'h00;
  logic [4:0]  pwmOut = 5'h00;
  logic        serialTxEn = 1'b0;
  logic        serialRxEn = 1'b0;
  logic        serialTxData = 1'b0;
  logic [3:0]  extEn = 4'h0;
  logic [3:0]  extVal = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serialRxData;
  logic [4:0]  portTToModulator;
  logic [4:0]  portTPeriphOut;
  logic [7:0]  portTPullUp;
  logic [7:0]  portTPullDown;
  logic [3:0]  portSPinIn;
  logic [3:0]  portSPinOut;
  logic [3:0]  portSPinOeN;
  logic [3:0]  portSReducedDrive;
  logic [3:0]  portSPullUp;
  logic [3:0]  portSPullDown;
  logic [31:0] rd;
  logic        err;
  int          fails = 0;
  int          total_checks = 0;
  regIdx_t     idxs[7] = '{IDX_T_PULL_EN, IDX_T_PULL_POL, IDX_T_ROUTING, IDX_S_DRIVE, IDX_S_PULL_EN,
                           IDX_S_PULL_POL, IDX_S_OPEN_DRN};
  logic [31:0] rstv[7] = '{32'(RST_T_PULL_EN), 32'(RST_T_PULL_POL), 32'(RST_T_ROUTING), 32'(RST_S_DRIVE),
                           32'(RST_S_PULL_EN), 32'(RST_S_PULL_POL), 32'(RST_S_OPEN_DRN)};
  logic [31:0] msk[7] = '{32'hff, 32'hff, 32'h1f, 32'hf, 32'hf, 32'hf, 32'hf};
  logic [11:0] bad[4] = '{12'h018, 12'h03c, 12'h021, 12'h040};

  always #10 sys_clk = ~sys_clk;

  port_ts_ctrl u_dut (.sys_clk, .nrst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .portTDirIn, .timerOut, .pwmOut, .portTToModulator, .portTPeriphOut,
    .portTPullUp, .portTPullDown, .serialTxEn, .serialRxEn, .serialTxData, .serialRxData, .portSPinIn,
    .portSPinOut, .portSPinOeN, .portSReducedDrive, .portSPullUp, .portSPullDown);
  pin_model u_pins (.sys_clk, .pinOut(portSPinOut), .pinOeN(portSPinOeN), .pullUp(portSPullUp),
    .pullDown(portSPullDown), .extEn, .extVal, .level(portSPinIn));

  // --------
  // Tasks
  // --------
  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer, entered just after an edge; an idle edge after it keeps strobes single-driven
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      print_verdict();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Pin flops take a new register value one edge after the write, so let that edge pass before any look
  task automatic wr(input regIdx_t i, input logic [31:0] d);
    apb(1'b1, {6'h0, i, 2'b00}, d);
    @(posedge sys_clk);
  endtask

  task automatic rchk(input regIdx_t i, input logic [31:0] exp);
    apb(1'b0, {6'h0, i, 2'b00}, 32'h0);
    check(rd, exp);
  endtask

  // --------
  // Sequence
  // --------
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    // Reset values, then ones written and unused bits read zero
    foreach (idxs[i]) begin
      rchk(idxs[i], rstv[i]);
      wr(idxs[i], 32'hffffffff);
      rchk(idxs[i], msk[i]);
      wr(idxs[i], rstv[i]);
    end
    rchk(IDX_S_DIR, 32'(RST_S_DIR));
    rchk(IDX_S_DATA, 32'hf);
    check(portSPullUp, 4'hf);
    wr(IDX_S_LEVELS, 32'h0);
    rchk(IDX_S_LEVELS, 32'hf);
    foreach (bad[i]) begin
      apb(1'b0, bad[i], 32'h0);
      check(rd, 32'h0);
      check(32'(err), 32'h1);
    end
    pstrb <= 4'h0;
    wr(IDX_S_DRIVE, 32'hf);
    pstrb <= 4'hf;
    rchk(IDX_S_DRIVE, 32'h0);
    // Mixed directions; pin 1 shorted high against a driven low
    extEn  <= 4'he;
    extVal <= 4'ha;
    wr(IDX_S_DATA, 32'h5);
    wr(IDX_S_DIR, 32'h3);
    check({portSPinOeN, portSPinOut}, 8'hc5);
    rchk(IDX_S_DATA, 32'h9);
    rchk(IDX_S_LEVELS, 32'hb);
    // Open-drain outputs drive low only and keep the pull-up
    extEn <= 4'h0;
    wr(IDX_S_OPEN_DRN, 32'hf);
    wr(IDX_S_DIR, 32'hf);
    check({portSPinOut, portSPinOeN, portSPullUp}, 12'h05f);
    rchk(IDX_S_LEVELS, 32'h5);
    wr(IDX_S_PULL_POL, 32'hf);
    check({portSPullUp, portSPullDown}, 8'h00);
    // Push-pull outputs take no pull; inputs take the pull-down
    wr(IDX_S_OPEN_DRN, 32'h0);
    wr(IDX_S_PULL_POL, 32'h0);
    wr(IDX_S_DRIVE, 32'hf);
    check({portSPullUp, portSReducedDrive}, 8'h0f);
    wr(IDX_S_PULL_POL, 32'hf);
    wr(IDX_S_DIR, 32'h0);
    check(portSPullDown, 4'hf);
    check(portSReducedDrive, 4'h0);
    rchk(IDX_S_DATA, 32'h0);
    // Serial channels override the direction bits, then hand back
    serialTxEn   <= 1'b1;
    serialTxData <= 1'b1;
    serialRxEn   <= 1'b1;
    extEn        <= 4'h1;
    extVal       <= 4'h0;
    wr(IDX_S_DIR, 32'h1);
    check({portSPinOeN[1:0], portSPinOut[1], serialRxData}, 4'h6);
    rchk(IDX_S_DATA, 32'h0);
    serialTxEn <= 1'b0;
    serialRxEn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(portSPinOeN[1:0], 2'b10);
    // Port T pulls and routing; bit 4 left clear
    portTDirIn <= 8'h33;
    timerOut   <= 5'h1f;
    wr(IDX_T_PULL_EN, 32'hff);
    wr(IDX_T_PULL_POL, 32'h0f);
    wr(IDX_T_ROUTING, 32'h0a);
    check({portTPullUp, portTPullDown}, 16'hc00c);
    check({portTToModulator, portTPeriphOut}, 10'h155);
    // Clock enable low freezes every flop, pin controls included
    clkEn      <= 1'b0;
    portTDirIn <= 8'hff;
    repeat (3) @(posedge sys_clk);
    check(portTPullUp, 8'hc0);
    clkEn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(portTPullUp, 8'h00);
    print_verdict();
  end
endmodule
